//--- hdl/pae_regs.sv
// management register bank: autoneg expansion, special control, interrupt control/status
// assumes a management frame engine issuing single-cycle read/write strobes on sys_clk,
// and status inputs from autoneg/PCS logic synchronous to sys_clk
//
// Overview of operation
// - expansion bits 15:5 read zero and ignore writes.
// - expansion bit 4 shows multiple link fault, reset zero.
// - expansion bit 3 shows partner next page capability.
// - expansion bit 2 shows local next page capability, reset zero.
// - expansion bit 1 sets on page received, clears on address 5 read.
// - expansion bit 0 shows partner autoneg capability.
// - control bit 15 selects debug mode, driving only the debug_mode output.
// - control bit 11 disables automatic crossover swapping, reset zero.
// - control bits 10 and 9 enable heartbeat and jabber for 10 Mb/s.
// - control bit 8 enables far-end fault for 100 Mb/s, reset zero.
// - control bit 7 blocks analog power saving during autonegotiation.
// - control bit 5 bypasses the signal processor reset in PCS.
// - control bit 2 selects repeater mode, reset zero.
// - control bit 1 enables automatic power saving, reset zero.
// - control bit 0 powers down analog transceiver, reset zero.
// - interrupt bit 15 enables the interrupt pin, else pin floats.
// - interrupt bit 11 masks all events, reset one.
// - interrupt bits 10, 9, 8 mask speed, duplex, link; 10 and 9 reset one, 8 resets zero.
// - interrupt bit 7 enables arbiter change interrupts, reset zero.
// - interrupt bit 6 flags arbiter change, clears on read.
// - interrupt bits 2, 1, 0 flag speed, duplex, link changes; read clears.
// - address 5 reads zero here; reading it clears page received.
`timescale 1ns/100ps
module pae_regs
  import pae_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        mgmt_rd,
  input  wire logic        mgmt_wr,
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic [15:0] mgmt_wdata,
  output logic      [15:0] mgmt_rdata,
  output logic             mgmt_rvalid,
  input  wire logic        multi_link_fault,
  input  wire logic        partner_next_page_capable,
  input  wire logic        local_next_page_capable,
  input  wire logic        partner_autoneg_capable,
  input  wire logic        page_received,
  input  wire logic        speed_status,
  input  wire logic        duplex_status,
  input  wire logic        link_status,
  input  wire logic [3:0]  arbiter_state,
  output logic             debug_mode,
  output logic             auto_crossover_disable,
  output logic             heartbeat_enable,
  output logic             jabber_enable,
  output logic             far_end_fault_enable,
  output logic             an_power_save_disable,
  output logic             dsp_reset_bypass,
  output logic             repeater_mode,
  output logic             auto_power_save_enable,
  output logic             analog_power_down,
  output logic             irq_out,
  output logic             irq_out_oe_n
);

  logic [15:0] special_q;
  logic [15:0] irq_ctrl_q;
  logic [3:0]  irq_flags_q;
  logic        page_rx_q;
  logic        fault_seen_q;
  logic        partner_np_q;
  logic        local_np_q;
  logic        partner_an_q;
  logic [6:0]  mon_now;
  logic [6:0]  mon_prev_q;
  logic [6:0]  mon_diff;
  logic        prev_valid_q;
  logic        wr_special;
  logic        wr_irq;
  logic [15:0] exp_value;
  logic [15:0] irq_value;
  logic [3:0]  evt;
  logic        rd_irq;
  logic        rd_lp;
  logic        irq_d;

  assign rd_irq = mgmt_rd && (mgmt_addr == PAE_ADDR_IRQ_CTRL);
  assign rd_lp  = mgmt_rd && (mgmt_addr == PAE_ADDR_LP_ABILITY);
  assign wr_special = mgmt_wr && (mgmt_addr == PAE_ADDR_SPECIAL_CTRL);
  assign wr_irq     = mgmt_wr && (mgmt_addr == PAE_ADDR_IRQ_CTRL);

  // status sampled for readback, one flop per source
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fault_seen_q <= 1'b0;
    end else if (clk_en) begin
      fault_seen_q <= multi_link_fault;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      partner_np_q <= 1'b0;
    end else if (clk_en) begin
      partner_np_q <= partner_next_page_capable;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      local_np_q <= 1'b0;
    end else if (clk_en) begin
      local_np_q <= local_next_page_capable;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      partner_an_q <= 1'b0;
    end else if (clk_en) begin
      partner_an_q <= partner_autoneg_capable;
    end
  end

  // page received: set wins over the clearing read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      page_rx_q <= 1'b0;
    end else if (clk_en) begin
      if (page_received) begin
        page_rx_q <= 1'b1;
      end else if (rd_lp) begin
        page_rx_q <= 1'b0;
      end
    end
  end

  always_comb begin
    exp_value               = PAE_EXPANSION_RESET;
    exp_value[PAE_EXP_MLF]  = fault_seen_q;
    exp_value[PAE_EXP_LPNP] = partner_np_q;
    exp_value[PAE_EXP_NP]   = local_np_q;
    exp_value[PAE_EXP_PAGE] = page_rx_q;
    exp_value[PAE_EXP_LPAN] = partner_an_q;
  end

  // special control register, reserved bits stay zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      special_q <= PAE_SPECIAL_RESET;
    end else if (clk_en && wr_special) begin
      special_q <= mgmt_wdata & PAE_SPECIAL_WMASK;
    end
  end

  // interrupt control bits
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_ctrl_q <= PAE_IRQ_RESET;
    end else if (clk_en && wr_irq) begin
      irq_ctrl_q <= mgmt_wdata & PAE_IRQ_WMASK;
    end
  end

  // previous monitored values for change detection
  assign mon_now = {arbiter_state, speed_status, duplex_status, link_status};

  for (genvar i = 0; i < 7; i++) begin : g_mon
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        mon_prev_q[i] <= 1'b0;
      end else if (clk_en) begin
        mon_prev_q[i] <= mon_now[i];
      end
    end
    assign mon_diff[i] = mon_now[i] ^ mon_prev_q[i];
  end

  // first sample after reset has no valid history
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prev_valid_q <= 1'b0;
    end else if (clk_en) begin
      prev_valid_q <= 1'b1;
    end
  end

  // events only on a real change after the first sample
  assign evt[3] = prev_valid_q && (|mon_diff[6:3]);
  assign evt[2] = prev_valid_q && mon_diff[2];
  assign evt[1] = prev_valid_q && mon_diff[1];
  assign evt[0] = prev_valid_q && mon_diff[0];

  // sticky flags, cleared by a read, set wins
  for (genvar f = 0; f < 4; f++) begin : g_flag
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        irq_flags_q[f] <= 1'b0;
      end else if (clk_en) begin
        irq_flags_q[f] <= (irq_flags_q[f] && !rd_irq) || evt[f];
      end
    end
  end

  always_comb begin
    irq_value               = irq_ctrl_q;
    irq_value[PAE_IR_ARBF]  = irq_flags_q[3];
    irq_value[PAE_IR_SPDF]  = irq_flags_q[2];
    irq_value[PAE_IR_DUPF]  = irq_flags_q[1];
    irq_value[PAE_IR_LNKF]  = irq_flags_q[0];
  end

  // read data returned one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mgmt_rvalid <= 1'b0;
    end else if (clk_en) begin
      mgmt_rvalid <= mgmt_rd;
    end
  end

  // read data holds until the next read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mgmt_rdata <= 16'h0000;
    end else if (clk_en && mgmt_rd) begin
      if (mgmt_addr == PAE_ADDR_AN_EXPANSION) begin
        mgmt_rdata <= exp_value;
      end else if (mgmt_addr == PAE_ADDR_SPECIAL_CTRL) begin
        mgmt_rdata <= special_q;
      end else if (mgmt_addr == PAE_ADDR_IRQ_CTRL) begin
        mgmt_rdata <= irq_value;
      end else begin
        mgmt_rdata <= 16'h0000;
      end
    end
  end

  // control outputs registered from the special register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      debug_mode <= 1'b0;
    end else if (clk_en) begin
      debug_mode <= special_q[PAE_SC_DEBUG];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      auto_crossover_disable <= 1'b0;
    end else if (clk_en) begin
      auto_crossover_disable <= special_q[PAE_SC_XOVER];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      heartbeat_enable <= 1'b0;
    end else if (clk_en) begin
      heartbeat_enable <= special_q[PAE_SC_HBEAT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      jabber_enable <= 1'b0;
    end else if (clk_en) begin
      jabber_enable <= special_q[PAE_SC_JABBER];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      far_end_fault_enable <= 1'b0;
    end else if (clk_en) begin
      far_end_fault_enable <= special_q[PAE_SC_FEF];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      an_power_save_disable <= 1'b0;
    end else if (clk_en) begin
      an_power_save_disable <= special_q[PAE_SC_APSDIS];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dsp_reset_bypass <= 1'b0;
    end else if (clk_en) begin
      dsp_reset_bypass <= special_q[PAE_SC_DSPBYP];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      repeater_mode <= 1'b0;
    end else if (clk_en) begin
      repeater_mode <= special_q[PAE_SC_RPT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      auto_power_save_enable <= 1'b0;
    end else if (clk_en) begin
      auto_power_save_enable <= special_q[PAE_SC_APS];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      analog_power_down <= 1'b0;
    end else if (clk_en) begin
      analog_power_down <= special_q[PAE_SC_AOFF];
    end
  end

  always_comb begin
    irq_d = (irq_flags_q[2] && !irq_ctrl_q[PAE_IR_SPDM])
         || (irq_flags_q[1] && !irq_ctrl_q[PAE_IR_DUPM])
         || (irq_flags_q[0] && !irq_ctrl_q[PAE_IR_LNKM])
         || (irq_flags_q[3] && irq_ctrl_q[PAE_IR_ARBEN]);
    irq_d = irq_d && !irq_ctrl_q[PAE_IR_ALL]
         && irq_ctrl_q[PAE_IR_PIN];
  end

  // interrupt pin: active high, floats while pin disabled
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
    end else if (clk_en) begin
      irq_out <= irq_d;
    end
  end

  // pin enable follows bit 15, so a disabled pin never drives
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_out_oe_n <= 1'b1;
    end else if (clk_en) begin
      irq_out_oe_n <= !irq_ctrl_q[PAE_IR_PIN];
    end
  end

endmodule : pae_regs

//--- hdl/pae_pkg.sv
// package for the autoneg expansion / special control / interrupt register bank
// assumes a 5-bit management register address and 16-bit data
package pae_pkg;
  localparam logic [4:0]  PAE_ADDR_LP_ABILITY   = 5'h05;
  localparam logic [4:0]  PAE_ADDR_AN_EXPANSION = 5'h06;
  localparam logic [4:0]  PAE_ADDR_SPECIAL_CTRL = 5'h10;
  localparam logic [4:0]  PAE_ADDR_IRQ_CTRL     = 5'h11;
  localparam logic [15:0] PAE_EXPANSION_RESET   = 16'h0000;
  localparam logic [15:0] PAE_SPECIAL_RESET     = 16'h0000;
  localparam logic [15:0] PAE_IRQ_RESET         = 16'h0E00;
  // writable bits of the special control register
  localparam logic [15:0] PAE_SPECIAL_WMASK     = 16'h8FA7;
  // writable bits of the interrupt control register
  localparam logic [15:0] PAE_IRQ_WMASK         = 16'h8F80;
  localparam int PAE_EXP_MLF   = 4;
  localparam int PAE_EXP_LPNP  = 3;
  localparam int PAE_EXP_NP    = 2;
  localparam int PAE_EXP_PAGE  = 1;
  localparam int PAE_EXP_LPAN  = 0;
  localparam int PAE_SC_DEBUG  = 15;
  localparam int PAE_SC_XOVER  = 11;
  localparam int PAE_SC_HBEAT  = 10;
  localparam int PAE_SC_JABBER = 9;
  localparam int PAE_SC_FEF    = 8;
  localparam int PAE_SC_APSDIS = 7;
  localparam int PAE_SC_DSPBYP = 5;
  localparam int PAE_SC_RPT    = 2;
  localparam int PAE_SC_APS    = 1;
  localparam int PAE_SC_AOFF   = 0;
  localparam int PAE_IR_PIN    = 15;
  localparam int PAE_IR_ALL    = 11;
  localparam int PAE_IR_SPDM   = 10;
  localparam int PAE_IR_DUPM   = 9;
  localparam int PAE_IR_LNKM   = 8;
  localparam int PAE_IR_ARBEN  = 7;
  localparam int PAE_IR_ARBF   = 6;
  localparam int PAE_IR_SPDF   = 2;
  localparam int PAE_IR_DUPF   = 1;
  localparam int PAE_IR_LNKF   = 0;
endpackage : pae_pkg

//--- testbench/pae_regs_properties.sv
// checker for the management register bank
// assumes one sys_clk domain; bound to pae_regs below
`timescale 1ns/100ps
module pae_regs_properties
  import pae_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        mgmt_rd,
  input wire logic        mgmt_wr,
  input wire logic [4:0]  mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic        link_status,
  input wire logic        repeater_mode,
  input wire logic        irq_out,
  input wire logic        irq_out_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire rd_c = mgmt_rd && clk_en;
  wire rd11 = rd_c && mgmt_addr == 5'h11;
  wire wr11 = mgmt_wr && clk_en && mgmt_addr == 5'h11;
  exp_high_zero_a:
    assert property (rd_c && mgmt_addr == 5'h06 |=> mgmt_rdata[15:5] == 11'h000)
    else $error("expansion reserved bits set");
  ctrl_rsvd_zero_a:
    assert property (rd_c && mgmt_addr == 5'h10 |=> (mgmt_rdata & 16'h7058) == 16'h0000)
    else $error("control reserved bits set");
  irq_rsvd_zero_a:
    assert property (rd11 |=> (mgmt_rdata & 16'h7038) == 16'h0000)
    else $error("interrupt reserved bits set");
  repeater_out_a:
    assert property ((mgmt_wr && clk_en && mgmt_addr == 5'h10 && mgmt_wdata[2]) ##1 clk_en
      |=> repeater_mode)
    else $error("repeater output not set");
  pin_float_a:
    assert property ((wr11 && !mgmt_wdata[15]) ##1 clk_en |=> irq_out_oe_n)
    else $error("pin driven while disabled");
  irq_needs_pin_a:
    assert property (irq_out |-> !irq_out_oe_n)
    else $error("interrupt high on floating pin");
  all_mask_a:
    assert property ((wr11 && mgmt_wdata[11]) ##1 clk_en |=> !irq_out)
    else $error("interrupt despite global mask");
  flag_rdclear_a:
    assert property ((rd11 && $stable(link_status)) ##1 (clk_en && $stable(link_status))
      ##1 (rd11 && $stable(link_status)) |=> !mgmt_rdata[0])
    else $error("link flag not cleared by read");
  cover property (rd11);
  cover property ($rose(irq_out));
  cover property (mgmt_wr && mgmt_addr == 5'h10);
endmodule : pae_regs_properties

bind pae_regs pae_regs_properties u_props (.sys_clk, .rst_n, .clk_en, .mgmt_rd, .mgmt_wr,
  .mgmt_addr, .mgmt_wdata, .mgmt_rdata, .link_status, .repeater_mode, .irq_out, .irq_out_oe_n);

//--- testbench/pae_mgmt_host.sv
// management controller model: single register reads and writes
// assumes the bank takes strobes at the rising edge of sys_clk
`timescale 1ns/100ps
module pae_mgmt_host (
  input  wire logic        sys_clk,
  input  wire logic [15:0] mgmt_rdata,
  input  wire logic        mgmt_rvalid,
  output logic             mgmt_rd,
  output logic             mgmt_wr,
  output logic      [4:0]  mgmt_addr,
  output logic      [15:0] mgmt_wdata
);
  initial begin
    mgmt_rd = 1'b0;
    mgmt_wr = 1'b0;
    mgmt_addr = 5'h1F;
    mgmt_wdata = 16'hA5C3;
  end
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk) #1;
    mgmt_wr = 1'b1;
    mgmt_addr = a;
    mgmt_wdata = d;
    @(posedge sys_clk) #1;
    mgmt_wr = 1'b0;
    mgmt_wdata = ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d, output logic ok);
    @(posedge sys_clk) #1;
    mgmt_rd = 1'b1;
    mgmt_addr = a;
    @(posedge sys_clk) #1;
    mgmt_rd = 1'b0;
    d = mgmt_rdata;
    ok = mgmt_rvalid;
  endtask : rd_reg
endmodule : pae_mgmt_host

//--- testbench/tb_pae_regs.sv
// self-checking bench for pae_regs driven by a management controller model
// assumes a 200 MHz sys_clk and a synchronous active-low reset
`timescale 1ns/100ps
module tb_pae_regs import pae_pkg::*; ;
  logic sys_clk, rst_n, clk_en, mgmt_rd, mgmt_wr, page_received;
  logic multi_link_fault, partner_next_page_capable, local_next_page_capable;
  logic partner_autoneg_capable, speed_status, duplex_status, link_status;
  logic [3:0]  arbiter_state;
  logic [4:0]  mgmt_addr;
  logic [15:0] mgmt_wdata;
  wire  [15:0] mgmt_rdata;
  wire mgmt_rvalid, debug_mode, auto_crossover_disable, heartbeat_enable, jabber_enable;
  wire far_end_fault_enable, an_power_save_disable, dsp_reset_bypass, repeater_mode;
  wire auto_power_save_enable, analog_power_down, irq_out, irq_out_oe_n;
  int err_total = 0;
  int n_tests = 0;
  pae_regs u_dut (.sys_clk, .rst_n, .clk_en, .mgmt_rd, .mgmt_wr, .mgmt_addr, .mgmt_wdata,
    .mgmt_rdata, .mgmt_rvalid, .multi_link_fault, .partner_next_page_capable,
    .local_next_page_capable, .partner_autoneg_capable, .page_received, .speed_status,
    .duplex_status, .link_status, .arbiter_state, .debug_mode, .auto_crossover_disable,
    .heartbeat_enable, .jabber_enable, .far_end_fault_enable, .an_power_save_disable,
    .dsp_reset_bypass, .repeater_mode, .auto_power_save_enable, .analog_power_down,
    .irq_out, .irq_out_oe_n);
  pae_mgmt_host u_host (.sys_clk, .mgmt_rdata, .mgmt_rvalid, .mgmt_rd, .mgmt_wr,
    .mgmt_addr, .mgmt_wdata);
  wire [15:0] ctl = {6'h00, debug_mode, auto_crossover_disable, heartbeat_enable,
    jabber_enable, far_end_fault_enable, an_power_save_disable, dsp_reset_bypass,
    repeater_mode, auto_power_save_enable, analog_power_down};
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    u_host.rd_reg(a, d, ok);
    chk16({15'h0000, ok}, 16'h0001);
    chk16(d, exp);
  endtask : rd_chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic t_reset;
    rd_chk(PAE_ADDR_AN_EXPANSION, 16'h0000);
    rd_chk(PAE_ADDR_SPECIAL_CTRL, 16'h0000);
    rd_chk(PAE_ADDR_IRQ_CTRL, 16'h0E00);
    chk16({irq_out_oe_n, irq_out}, 16'h0002);
    $display("reset test done");
  endtask : t_reset
  task automatic t_expansion;
    {multi_link_fault, partner_next_page_capable} = 2'b11;
    {local_next_page_capable, partner_autoneg_capable} = 2'b11;
    u_host.wr_reg(PAE_ADDR_AN_EXPANSION, 16'hFFFF);
    rd_chk(PAE_ADDR_AN_EXPANSION, 16'h001D);
    {multi_link_fault, partner_next_page_capable} = 2'b00;
    {local_next_page_capable, partner_autoneg_capable} = 2'b00;
    page_received = 1'b1;
    cyc(1);
    page_received = 1'b0;
    rd_chk(PAE_ADDR_AN_EXPANSION, 16'h0002);
    rd_chk(PAE_ADDR_AN_EXPANSION, 16'h0002);
    rd_chk(PAE_ADDR_LP_ABILITY, 16'h0000);
    rd_chk(PAE_ADDR_AN_EXPANSION, 16'h0000);
    $display("expansion test done");
  endtask : t_expansion
  task automatic t_ctrl;
    u_host.wr_reg(PAE_ADDR_SPECIAL_CTRL, 16'hFFFF);
    rd_chk(PAE_ADDR_SPECIAL_CTRL, 16'h8FA7);
    chk16(ctl, 16'h03FF);
    u_host.wr_reg(PAE_ADDR_SPECIAL_CTRL, 16'h0804);
    rd_chk(PAE_ADDR_SPECIAL_CTRL, 16'h0804);
    chk16(ctl, 16'h0104);
    $display("control test done");
  endtask : t_ctrl
  task automatic t_freeze;
    clk_en = 1'b0;
    u_host.wr_reg(PAE_ADDR_SPECIAL_CTRL, 16'h0001);
    clk_en = 1'b1;
    rd_chk(PAE_ADDR_SPECIAL_CTRL, 16'h0804);
    chk16(ctl, 16'h0104);
    $display("freeze test done");
  endtask : t_freeze
  task automatic t_irq;
    logic [15:0] d;
    logic ok;
    u_host.wr_reg(PAE_ADDR_IRQ_CTRL, 16'h8080);
    link_status = 1'b1;
    cyc(3);
    chk16({irq_out_oe_n, irq_out}, 16'h0001);
    rd_chk(PAE_ADDR_IRQ_CTRL, 16'h8081);
    cyc(1);
    chk16({15'h0000, irq_out}, 16'h0000);
    {speed_status, duplex_status, arbiter_state} = 6'h35;
    cyc(3);
    rd_chk(PAE_ADDR_IRQ_CTRL, 16'h80C6);
    rd_chk(PAE_ADDR_IRQ_CTRL, 16'h8080);
    u_host.wr_reg(PAE_ADDR_IRQ_CTRL, 16'hFFFF);
    rd_chk(PAE_ADDR_IRQ_CTRL, 16'h8F80);
    link_status = 1'b0;
    cyc(3);
    chk16({15'h0000, irq_out}, 16'h0000);
    u_host.wr_reg(PAE_ADDR_IRQ_CTRL, 16'h8780);
    link_status = 1'b1;
    cyc(3);
    chk16({15'h0000, irq_out}, 16'h0000);
    u_host.rd_reg(PAE_ADDR_IRQ_CTRL, d, ok);
    u_host.wr_reg(PAE_ADDR_IRQ_CTRL, 16'h8000);
    arbiter_state = 4'h1;
    cyc(3);
    chk16({15'h0000, irq_out}, 16'h0000);
    u_host.wr_reg(PAE_ADDR_IRQ_CTRL, 16'h0080);
    arbiter_state = 4'h2;
    cyc(3);
    chk16({irq_out_oe_n, irq_out}, 16'h0002);
    $display("interrupt test done");
  endtask : t_irq
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    {rst_n, clk_en, page_received, multi_link_fault} = 4'h4;
    {partner_next_page_capable, local_next_page_capable, partner_autoneg_capable} = 3'h0;
    {speed_status, duplex_status, link_status, arbiter_state} = 7'h08;
    repeat (6) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_expansion();
    t_ctrl();
    t_freeze();
    t_irq();
    rst_n = 1'b0;
    cyc(6);
    rst_n = 1'b1;
    t_reset();
    tally_and_finish();
  end
endmodule : tb_pae_regs
